// >>> logic/dac_channel_drive.sv
/*
  One converter channel: registers the code presented to the analog stage and
  pulses the conversion start. Assumes the top decodes writes and supplies the
  new code in the same cycle as the write strobe.
*/
module dac_channel_drive #(
  parameter int DATA_W = 8
) (
  input wire logic core_clk, // Block clock.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire logic enable, // Channel enable bit.
  input wire logic idle, // Chip is in Idle mode.
  input wire logic code_wr, // Code register written this cycle.
  input wire logic [DATA_W-1:0] code_next, // Code value after this cycle.
  output logic [DATA_W-1:0] drive_out, // Code presented to the converter.
  output logic conv_start // One-cycle conversion start.
);

  logic [DATA_W-1:0] drive_reg;
  logic [DATA_W-1:0] drive_next;
  logic start_reg;
  logic start_next;
  logic active;

  // ---------------------------------------------------------------
  // Output stage
  // ---------------------------------------------------------------
  always_comb begin
    active = enable && !idle;
    drive_next = active ? code_next : dac_ctrl_pkg::ZERO_VOLT_CODE;
    start_next = active && code_wr;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      drive_reg <= dac_ctrl_pkg::ZERO_VOLT_CODE;
      start_reg <= 1'b0;
    end else begin
      drive_reg <= drive_next;
      start_reg <= start_next;
    end
  end

  assign drive_out = drive_reg;
  assign conv_start = start_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_off_zero: assert property ((!enable || idle) |=> drive_out == '0)
    else $error("disabled channel does not drive zero");
  chk_follow_code: assert property ((enable && !idle) |=> drive_out == $past(code_next))
    else $error("enabled channel does not follow its code");
  chk_start_pulse: assert property ((enable && !idle && code_wr) |=> conv_start && drive_out == $past(code_next))
    else $error("write on enabled channel did not start conversion");
  chk_start_cause: assert property (conv_start |-> $past(code_wr) && $past(enable) && !$past(idle))
    else $error("conversion start without an enabled write");

  cov_enabled_write: cover property (enable && !idle && code_wr);
  cov_idle_entry: cover property (enable && $rose(idle));

endmodule : dac_channel_drive

// >>> logic/dac_ctrl_pkg.sv
/*
  Shared constants and types for the four-channel converter control block.
  Assumes a byte-wide peripheral bus whose requests are synchronous to core_clk.
*/
package dac_ctrl_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NUM_CH = 4;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 3;
  localparam int EN_W = 4;

  // ---------------------------------------------------------------
  // Register indices on the peripheral bus
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] IDX_ENABLE_CTRL = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_CODE_BASE = 3'h1;

  // ---------------------------------------------------------------
  // Reset values and fixed levels
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] ENABLE_CTRL_RESET = 8'h00;
  localparam logic [DATA_W-1:0] CODE_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_VOLT_CODE = 8'h00;
  localparam logic [DATA_W-1:0] RESERVED_READ = 8'h00;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b01,
    MODE_IDLE = 2'b10
  } power_mode_t;

endpackage : dac_ctrl_pkg

// >>> logic/quad_dac_channel_control.sv
/*
  Control logic of a four-channel 8-bit converter: one enable control register,
  four code registers, Idle-mode shutdown and per-channel output codes.
  Assumes a synchronous byte-wide peripheral bus from the processor core and
  that rstn is asserted for both the power-up detect and the hardware master
  reset pin.
*/
// Notes on behaviour
// - Four independent channels, each an 8-bit unsigned code driving its own output.
// - Code register n drives output n only; writes never disturb other channels.
// - After any reset all channels are disabled and every output is at 0 V.
// - Enabled channel output equals code over 256 times the analog supply.
// - Enable bits 3 to 0 enable the channel of matching index.
// - A channel with its enable bit clear drives 0 V whatever its code.
// - In Idle mode every channel is off and drives 0 V, ignoring enables.
// - A code write on an enabled channel outside Idle mode starts a conversion to the new value.
// - Enable register returns to default on power-up and hardware master reset.
// - Enable register is byte-wide read/write, bits clear on reset, 7 to 4 reserved.
// - Code registers are byte-wide read/write and read back the last written value.
// - Each channel enable bit changes independently of the other channels.
// - Idle shutdown leaves enable and code registers unchanged.
module quad_dac_channel_control #(
  parameter int NUM_CH = dac_ctrl_pkg::NUM_CH,
  parameter int DATA_W = dac_ctrl_pkg::DATA_W
) (
  input wire logic core_clk, // Block clock, 20 MHz.
  input wire logic rstn, // Asynchronous reset, active low.
  input wire dac_ctrl_pkg::bus_req_t bus_req, // Peripheral bus request.
  input wire logic idle_mode, // Chip Idle mode level.
  output logic [DATA_W-1:0] rd_data, // Read data, valid with rd_valid.
  output logic rd_valid, // One-cycle read answer.
  output logic [NUM_CH-1:0][DATA_W-1:0] dac_out, // Codes to the analog outputs.
  output logic [NUM_CH-1:0] conv_start // Per-channel conversion start.
);

  logic [dac_ctrl_pkg::EN_W-1:0] enable_reg;
  logic [dac_ctrl_pkg::EN_W-1:0] enable_next;
  logic [NUM_CH-1:0][DATA_W-1:0] code_reg;
  logic [NUM_CH-1:0][DATA_W-1:0] code_next;
  logic [NUM_CH-1:0] code_wr;
  dac_ctrl_pkg::power_mode_t mode_reg;
  dac_ctrl_pkg::power_mode_t mode_next;
  logic [DATA_W-1:0] rd_data_reg;
  logic [DATA_W-1:0] rd_data_next;
  logic rd_valid_reg;
  logic rd_valid_next;
  logic enable_sel;

  // ---------------------------------------------------------------
  // Enable control register
  // ---------------------------------------------------------------
  always_comb begin
    enable_sel = bus_req.addr == dac_ctrl_pkg::IDX_ENABLE_CTRL;
    enable_next = enable_reg;
    if (bus_req.wr && enable_sel) begin
      enable_next = bus_req.wdata[dac_ctrl_pkg::EN_W-1:0];
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= dac_ctrl_pkg::ENABLE_CTRL_RESET[dac_ctrl_pkg::EN_W-1:0];
    end else begin
      enable_reg <= enable_next;
    end
  end

  // ---------------------------------------------------------------
  // Power mode tracking
  // ---------------------------------------------------------------
  // Idle only gates the outputs; the registers keep their contents so that
  // software finds the same setup on wake-up.
  always_comb begin
    case (mode_reg)
      dac_ctrl_pkg::MODE_RUN: mode_next = idle_mode ? dac_ctrl_pkg::MODE_IDLE : dac_ctrl_pkg::MODE_RUN;
      dac_ctrl_pkg::MODE_IDLE: mode_next = idle_mode ? dac_ctrl_pkg::MODE_IDLE : dac_ctrl_pkg::MODE_RUN;
      default: mode_next = dac_ctrl_pkg::MODE_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mode_reg <= dac_ctrl_pkg::MODE_RUN;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // ---------------------------------------------------------------
  // Code registers and channel drives
  // ---------------------------------------------------------------
  // four channels
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    always_comb begin
      code_wr[ch] = bus_req.wr && (bus_req.addr == code_idx(ch));
      code_next[ch] = code_wr[ch] ? bus_req.wdata : code_reg[ch];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
        code_reg[ch] <= dac_ctrl_pkg::CODE_RESET;
      end else begin
        code_reg[ch] <= code_next[ch];
      end
    end

    dac_channel_drive #(
      .DATA_W(DATA_W)
    ) u_drive (
      .core_clk(core_clk),
      .rstn(rstn),
      .enable(enable_reg[ch]),
      .idle(mode_reg == dac_ctrl_pkg::MODE_IDLE),
      .code_wr(code_wr[ch]),
      .code_next(code_next[ch]),
      .drive_out(dac_out[ch]),
      .conv_start(conv_start[ch])
    );
  end

  // Maps a channel number to its code register index, cut to the bus index width on purpose.
  function automatic logic [dac_ctrl_pkg::ADDR_W-1:0] code_idx(input int ch);
    int sum;
    sum = int'(dac_ctrl_pkg::IDX_CODE_BASE) + ch;
    code_idx = sum[dac_ctrl_pkg::ADDR_W-1:0];
  endfunction : code_idx

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Unmapped indices read as zero so a stray read never returns stale data.
  always_comb begin
    rd_valid_next = bus_req.rd;
    rd_data_next = dac_ctrl_pkg::RESERVED_READ;
    if (bus_req.rd) begin
      if (enable_sel) begin
        rd_data_next = {dac_ctrl_pkg::RESERVED_READ[DATA_W-1:dac_ctrl_pkg::EN_W], enable_reg};
      end
      for (int k = 0; k < NUM_CH; k++) begin
        if (bus_req.addr == code_idx(k)) begin
          rd_data_next = code_reg[k];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rd_data_reg <= dac_ctrl_pkg::RESERVED_READ;
      rd_valid_reg <= 1'b0;
    end else begin
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
    end
  end

  assign rd_data = rd_data_reg;
  assign rd_valid = rd_valid_reg;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // Low only up to the first edge after reset, where the cleared state is checked.
  logic after_rst_reg;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      after_rst_reg <= 1'b0;
    end else begin
      after_rst_reg <= 1'b1;
    end
  end

  chk_reset_clear: assert property (!after_rst_reg |-> enable_reg == '0 && dac_out == '0 && conv_start == '0)
    else $error("state not cleared after reset");
  chk_ctrl_write: assert property ((bus_req.wr && bus_req.addr == dac_ctrl_pkg::IDX_ENABLE_CTRL)
      |=> enable_reg == $past(bus_req.wdata[dac_ctrl_pkg::EN_W-1:0]))
    else $error("enable write not stored bit for bit");
  chk_code_isolate: assert property ((bus_req.wr && bus_req.addr == code_idx(0))
      |=> code_reg[0] == $past(bus_req.wdata) && $stable(code_reg[NUM_CH-1:1]) && $stable(enable_reg))
    else $error("code write disturbed another register");
  chk_idle_shutdown: assert property (idle_mode |-> ##2 dac_out == '0)
    else $error("outputs not at zero in idle");
  chk_idle_retain: assert property ((mode_reg == dac_ctrl_pkg::MODE_IDLE && !bus_req.wr)
      |=> $stable(enable_reg) && $stable(code_reg))
    else $error("idle changed register contents");
  chk_read_code: assert property ((bus_req.rd && bus_req.addr == code_idx(2))
      |=> rd_valid && rd_data == $past(code_reg[2]))
    else $error("code readback mismatch");
  chk_reserved_zero: assert property ((bus_req.rd && bus_req.addr == dac_ctrl_pkg::IDX_ENABLE_CTRL)
      |=> rd_data[DATA_W-1:dac_ctrl_pkg::EN_W] == '0 && rd_data[dac_ctrl_pkg::EN_W-1:0] == $past(enable_reg))
    else $error("enable readback wrong");
  chk_resume_run: assert property ((mode_reg == dac_ctrl_pkg::MODE_IDLE && !idle_mode && enable_reg[1]
      && !bus_req.wr) |-> ##2 dac_out[1] == code_reg[1])
    else $error("channel did not resume after idle");
  chk_unmapped_write: assert property ((bus_req.wr && bus_req.addr > code_idx(NUM_CH - 1))
      |=> $stable(code_reg) && $stable(enable_reg))
    else $error("write to an unused index changed a register");
  chk_read_unmapped: assert property ((bus_req.rd && bus_req.addr > code_idx(NUM_CH - 1))
      |=> rd_valid && rd_data == dac_ctrl_pkg::RESERVED_READ)
    else $error("read of an unused index did not answer zero");
  chk_read_pulse: assert property (rd_valid |-> $past(bus_req.rd))
    else $error("read answer without a read");
  chk_write_silent: assert property ((bus_req.wr && !bus_req.rd) |=> !rd_valid)
    else $error("write gave a read answer");
  chk_idle_no_start: assert property (mode_reg == dac_ctrl_pkg::MODE_IDLE |=> conv_start == '0)
    else $error("conversion started in idle");

  cov_enable_all: cover property (enable_reg == 4'hF && mode_reg == dac_ctrl_pkg::MODE_RUN);
  cov_idle_exit: cover property (mode_reg == dac_ctrl_pkg::MODE_IDLE ##1 mode_reg == dac_ctrl_pkg::MODE_RUN);
  cov_read_ctrl: cover property (bus_req.rd && bus_req.addr == dac_ctrl_pkg::IDX_ENABLE_CTRL);

endmodule : quad_dac_channel_control

// >>> sim/cpu_bus_model.sv
/*
  Processor-side model that issues byte reads and writes to the converter block.
  Assumes the block never stalls and answers a read one cycle after taking it.
*/
module cpu_bus_model (
  input wire logic core_clk, // Block clock.
  input wire logic [7:0] rd_data, // Read answer data.
  input wire logic rd_valid, // Read answer strobe.
  output dac_ctrl_pkg::bus_req_t bus_req // Request to the block.
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    bus_req = '0;
  end

  // Requests change at the falling edge and are held over the taking edge.
  task automatic access(input logic wr, input logic [2:0] addr, input logic [7:0] data,
                        output logic [7:0] rdat, output logic vld);
    @(negedge core_clk);
    bus_req.wr = wr;
    bus_req.rd = !wr;
    bus_req.addr = addr;
    bus_req.wdata = data;
    @(negedge core_clk);
    rdat = rd_data;
    vld = rd_valid;
    bus_req.wr = 1'b0;
    bus_req.rd = 1'b0;
    // A released bus shows no stale value, so the last one is inverted.
    bus_req.addr = ~bus_req.addr;
    bus_req.wdata = ~bus_req.wdata;
  endtask : access
endmodule : cpu_bus_model

// >>> sim/quad_dac_channel_control_tb.sv
/*
  Self-checking bench for the converter control block with a behavioural model.
  Assumes the processor bus model in cpu_bus_model and a 20 MHz core clock.
*/
module quad_dac_channel_control_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic core_clk;
  logic rstn;
  logic idle_mode;
  dac_ctrl_pkg::bus_req_t bus_req;
  logic [7:0] rd_data;
  logic rd_valid;
  logic [3:0][7:0] dac_out;
  logic [3:0] conv_start;
  int errors;
  int checks;
  int cycles;
  int en_m;
  int code_m[4];
  bit idle_m;
  int k;

  quad_dac_channel_control u_dut (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
    .idle_mode(idle_mode), .rd_data(rd_data), .rd_valid(rd_valid), .dac_out(dac_out),
    .conv_start(conv_start));

  cpu_bus_model u_cpu (.core_clk(core_clk), .rd_data(rd_data), .rd_valid(rd_valid), .bus_req(bus_req));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ---------------------------------------------------------------
  // Comparison and register tasks
  // ---------------------------------------------------------------
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_byte

  task automatic check_flags(input logic [3:0] got, input logic [3:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_flags

  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    u_cpu.access(1'b0, a, 8'h00, d, v);
    check_flags({3'h0, v}, 4'h1);
    check_byte(d, exp);
  endtask : rd_reg

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    logic [7:0] x;
    logic v;
    logic [3:0] exp;
    exp = 4'h0;
    if (a >= 3'h1 && a <= 3'h4) begin
      exp[a-1] = en_m[a-1] && !idle_m;
    end
    u_cpu.access(1'b1, a, d, x, v);
    check_flags(conv_start, exp);
    check_flags({3'h0, v}, 4'h0);
    if (a == 3'h0) begin
      en_m = d & 15;
    end else if (a <= 3'h4) begin
      code_m[a-1] = d;
    end
  endtask : wr_reg

  // Outputs are compared once every update path has had time to land.
  task automatic check_all();
    repeat (3) @(negedge core_clk);
    for (int n = 0; n < 4; n++) begin
      check_byte(dac_out[n], (en_m[n] && !idle_m) ? 8'(code_m[n]) : 8'h00);
    end
    rd_reg(3'h0, 8'(en_m));
    for (int n = 0; n < 4; n++) begin
      rd_reg(3'(n + 1), 8'(code_m[n]));
    end
  endtask : check_all

  task automatic print_verdict();
    if (errors == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rstn = 1'b0;
    idle_mode = 1'b0;
    errors = 0;
    checks = 0;
    cycles = 0;
    en_m = 0;
    code_m = '{default: 0};
    idle_m = 1'b0;
    void'($urandom(42));
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    check_all();
    for (int a = 5; a < 8; a++) begin
      rd_reg(3'(a), 8'h00);
    end
    for (int n = 1; n < 5; n++) begin
      wr_reg(3'(n), 8'h00);
    end
    for (int i = 0; i < 60; i++) begin
      k = $urandom_range(0, 6);
      if (k == 6) begin
        idle_m = !idle_m;
        @(negedge core_clk);
        idle_mode = idle_m;
      end else if (k >= 4) begin
        wr_reg(3'h0, 8'($urandom));
      end else begin
        wr_reg(3'(k + 1), 8'($urandom));
      end
      if (i % 5 == 4) begin
        wr_reg(3'($urandom_range(5, 7)), 8'($urandom));
      end
      check_all();
    end
    // A second reset in mid-run must clear everything again.
    @(negedge core_clk);
    rstn = 1'b0;
    idle_mode = 1'b0;
    idle_m = 1'b0;
    en_m = 0;
    code_m = '{default: 0};
    @(negedge core_clk);
    for (int n = 0; n < 4; n++) begin
      check_byte(dac_out[n], 8'h00);
    end
    rstn = 1'b1;
    check_all();
    print_verdict();
  end
endmodule : quad_dac_channel_control_tb
